// ---- core/clk_sleep_ctrl.sv ----
// system clock divider, oscillator trim and sleep controller with apb registers
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module clk_sleep_ctrl
  import clk_sleep_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       PSEL,
  input  wire logic       PENABLE,
  input  wire logic       PWRITE,
  input  wire logic [7:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]     PRDATA,
  output logic            PREADY,
  output logic            PSLVERR,
  input  wire logic [7:0] FACTORY_TRIM,
  input  wire logic       DIVIDE_BY_EIGHT_FUSE,
  input  wire logic       SLEEP_EXEC,
  input  wire logic [8:0] WAKE_SRC,
  input  wire logic       T2_ASYNC,
  output logic [7:0]      OSCILLATOR_TRIM,
  output logic            CORE_CLK_EN,
  output logic            FLASH_CLK_EN,
  output logic            IO_CLK_EN,
  output logic            ADC_CLK_EN,
  output logic            ASY_CLK_EN,
  output logic            MAIN_OSC_EN,
  output logic            TIMER_OSC_EN,
  output logic            BOD_OFF,
  output logic            WAKE_PULSE
);

  logic [7:0]  trim;
  logic [3:0]  divider_select;
  logic        divider_change_enable;
  logic [2:0]  cde_cnt;
  logic [7:0]  div_cnt;
  logic        se_bit;
  logic        bods_bit;
  logic [2:0]  sleep_mode_field;
  pwr_state_t  state;
  pwr_state_t  next_state;
  logic [3:0]  wait_cnt;
  logic [2:0]  slept_mode;
  logic        acc;
  logic        wr;
  logic        wr_div;
  logic        mapped;
  logic        tick;
  logic        mode_ok;
  logic        deep;
  logic        wake;
  logic [8:0]  wmask;
  logic [6:0]  dom;
  logic [6:0]  sdom;
  logic [7:0]  div_wdata;

  function automatic logic [7:0] reload(input logic [3:0] sel);
    logic [8:0] t;
    t = 9'h001 << sel;
    return 8'(t - 9'h001);
  endfunction : reload

  function automatic logic [6:0] mode_dom(input logic [2:0] m);
    case (m)
      SM_IDLE:  return DOM_IDLE;
      SM_ADCNR: return DOM_ADCNR;
      SM_PDOWN: return DOM_PDOWN;
      SM_PSAVE: return DOM_PSAVE;
      SM_STBY:  return DOM_STBY;
      SM_XSTBY: return DOM_XSTBY;
      default:  return DOM_PDOWN;
    endcase
  endfunction : mode_dom

  function automatic logic [8:0] mode_wmask(input logic [2:0] m);
    case (m)
      SM_IDLE:  return WMASK_IDLE;
      SM_ADCNR: return WMASK_ADCNR;
      SM_PDOWN: return WMASK_PDOWN;
      SM_STBY:  return WMASK_PDOWN;
      SM_PSAVE: return WMASK_PSAVE;
      SM_XSTBY: return WMASK_PSAVE;
      default:  return 9'h000;
    endcase
  endfunction : mode_wmask

  // apb access phase, one wait state
  assign acc       = PSEL & PENABLE & PREADY;
  assign wr        = acc & PWRITE;
  assign mapped    = (PADDR == OFS_TRIM) | (PADDR == OFS_DIVCTL) |
                     (PADDR == OFS_SLEEPCTL) | (PADDR == OFS_STATUS);
  assign div_wdata = PWDATA[7:0];
  assign wr_div    = wr & (PADDR == OFS_DIVCTL);
  assign tick      = (div_cnt == 8'h00);

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      PRDATA <= 32'h0000_0000;
    else if (PSEL & PENABLE & ~PREADY)
    begin
      case (PADDR)
        OFS_TRIM:     PRDATA <= {24'h000000, trim};
        OFS_DIVCTL:   PRDATA <= {24'h000000, divider_change_enable, 3'h0, divider_select};
        OFS_SLEEPCTL: PRDATA <= {27'h0000000, bods_bit, sleep_mode_field, se_bit};
        OFS_STATUS:   PRDATA <= {24'h000000, 1'b0, cde_cnt, 2'h0, state};
        default:      PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // trim register, factory value at reset
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      trim <= FACTORY_TRIM;
    else if (wr & (PADDR == OFS_TRIM))
      trim <= div_wdata;
  end

  assign OSCILLATOR_TRIM = trim;

  // protected change-enable window
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      divider_change_enable <= 1'b0;
      cde_cnt               <= 3'h0;
    end
    else if (divider_change_enable)
    begin
      if (wr_div & (div_wdata != DIVCTL_CDE_ONLY))
      begin
        divider_change_enable <= 1'b0;
        cde_cnt               <= 3'h0;
      end
      else if (cde_cnt == CDE_WINDOW - 3'h1)
      begin
        divider_change_enable <= 1'b0;
        cde_cnt               <= 3'h0;
      end
      else
        cde_cnt <= cde_cnt + 3'h1;
    end
    else if (wr_div & (div_wdata == DIVCTL_CDE_ONLY))
    begin
      divider_change_enable <= 1'b1;
      cde_cnt               <= 3'h0;
    end
  end

  // divider select, fuse picks reset value
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      divider_select <= DIVIDE_BY_EIGHT_FUSE ? DIVSEL_RST_DIV8 : DIVSEL_RST_FAST;
    else if (wr_div & divider_change_enable & ~div_wdata[DIVCTL_CDE] &
             (div_wdata[3:0] <= DIVSEL_MAX))
      divider_select <= div_wdata[3:0];
  end

  // counter on master clock, reloads only at period end
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      div_cnt <= 8'h00;
    else if (tick)
      div_cnt <= reload(divider_select);
    else
      div_cnt <= div_cnt - 8'h01;
  end

  // sleep mode control register
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      se_bit           <= 1'b0;
      bods_bit         <= 1'b0;
      sleep_mode_field <= SM_IDLE;
    end
    else if (wr & (PADDR == OFS_SLEEPCTL))
    begin
      se_bit           <= PWDATA[SLP_SE];
      sleep_mode_field <= PWDATA[3:1];
      bods_bit         <= PWDATA[SLP_BODS];
    end
  end

  assign mode_ok = (sleep_mode_field != 3'h4) & (sleep_mode_field != 3'h5);
  assign wmask   = mode_wmask(slept_mode);
  assign wake    = |(WAKE_SRC & wmask);
  assign deep    = (slept_mode != SM_IDLE) & (slept_mode != SM_ADCNR);

  always_comb
  begin
    next_state = state;
    case (state)
      ST_RUN:
        if (SLEEP_EXEC & se_bit & mode_ok)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake)
          next_state = ST_START;
      ST_START:
        if (wait_cnt == STARTUP_CK - 4'h1)
          next_state = ST_HOLD;
      ST_HOLD:
        if (wait_cnt == HOLD_CK - 4'h1)
          next_state = ST_RUN;
      default:
        next_state = ST_RUN;
    endcase
  end

  // sync reset returns straight to run from any sleep state
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      wait_cnt <= 4'h0;
    else if (next_state != state)
      wait_cnt <= 4'h0;
    else if ((state == ST_START) | (state == ST_HOLD))
      wait_cnt <= wait_cnt + 4'h1;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      slept_mode <= SM_IDLE;
    else if ((state == ST_RUN) & (next_state == ST_SLEEP))
      slept_mode <= sleep_mode_field;
  end

  assign sdom = mode_dom(slept_mode);

  always_comb
  begin
    case (state)
      ST_RUN:   dom = DOM_RUN;
      ST_SLEEP: dom = sdom;
      ST_START: dom = sdom;
      ST_HOLD:  dom = DOM_IDLE;
      default:  dom = DOM_RUN;
    endcase
  end

  // registered gated enables; core, flash, io and adc pulse at divided rate, asy and oscillator enables are levels
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      CORE_CLK_EN  <= 1'b0;
      FLASH_CLK_EN <= 1'b0;
      IO_CLK_EN    <= 1'b0;
      ADC_CLK_EN   <= 1'b0;
      ASY_CLK_EN   <= 1'b0;
      MAIN_OSC_EN  <= 1'b1;
      TIMER_OSC_EN <= 1'b0;
    end
    else
    begin
      CORE_CLK_EN  <= tick & dom[0];
      FLASH_CLK_EN <= tick & dom[1];
      IO_CLK_EN    <= tick & dom[2];
      ADC_CLK_EN   <= tick & dom[3];
      ASY_CLK_EN   <= dom[4] & T2_ASYNC;
      MAIN_OSC_EN  <= dom[5];
      TIMER_OSC_EN <= dom[6] & T2_ASYNC;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      BOD_OFF    <= 1'b0;
      WAKE_PULSE <= 1'b0;
    end
    else
    begin
      BOD_OFF    <= (state == ST_SLEEP) & bods_bit & deep;
      WAKE_PULSE <= (state == ST_HOLD) & (next_state == ST_RUN);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  a_cde_needs_clean: assert property (
    $rose(divider_change_enable) |-> $past(wr_div) && ($past(div_wdata) == DIVCTL_CDE_ONLY))
    else $error("change enable set by unclean write");
  a_cde_window: assert property (
    $rose(divider_change_enable) |-> ##[1:4] !divider_change_enable)
    else $error("change enable window longer than four");
  a_sel_locked: assert property (
    !divider_change_enable |=> $stable(divider_select))
    else $error("divider select changed without enable");
  a_sel_valid: assert property (
    divider_select <= DIVSEL_MAX)
    else $error("reserved divider select stored");
  a_tick_period: assert property (
    tick |=> (div_cnt == reload($past(divider_select))))
    else $error("divider reload wrong");
  a_sleep_entry: assert property (
    (state == ST_RUN) && $past(state) == ST_RUN ##1 (state == ST_SLEEP)
      |-> $past(se_bit) && $past(SLEEP_EXEC))
    else $error("sleep entered without enable and instruction");
  a_core_stopped: assert property (
    (state != ST_RUN) && ($past(state) != ST_RUN) |-> !CORE_CLK_EN && !FLASH_CLK_EN)
    else $error("core clock running in sleep");
  a_hold_len: assert property (
    $rose(state == ST_HOLD) |-> (state == ST_HOLD)[*4] ##1 (state == ST_RUN))
    else $error("wake hold not four cycles");
  a_start_len: assert property (
    $rose(state == ST_START) |-> (state == ST_START)[*6] ##1 (state == ST_HOLD))
    else $error("start-up not six cycles");
  a_bod_modes: assert property (
    BOD_OFF |-> deep)
    else $error("brown-out disabled in shallow mode");
  a_pdown_dark: assert property (
    (state == ST_SLEEP) && (slept_mode == SM_PDOWN) ##1 (state == ST_SLEEP)
      |-> !IO_CLK_EN && !ADC_CLK_EN && !MAIN_OSC_EN && !ASY_CLK_EN)
    else $error("clock running in power-down");
  a_entry_taken: assert property (
    (state == ST_RUN) && SLEEP_EXEC && se_bit && mode_ok |=> (state == ST_SLEEP))
    else $error("sleep instruction not taken");
  a_edge_no_wake: assert property (
    (state == ST_SLEEP) && (slept_mode != SM_IDLE) &&
      ((WAKE_SRC & WMASK_ADCNR) == 9'h000) |=> (state == ST_SLEEP))
    else $error("edge or other request woke a deep mode");
  a_wdt_wakes: assert property (
    (state == ST_SLEEP) && WAKE_SRC[WK_WDT] |=> (state == ST_START))
    else $error("watchdog request did not wake");
  a_bod_in_sleep: assert property (
    (state != ST_SLEEP) |=> !BOD_OFF)
    else $error("brown-out left off outside sleep");
  a_cde_write_close: assert property (
    divider_change_enable && wr_div && (div_wdata != DIVCTL_CDE_ONLY)
      |=> !divider_change_enable)
    else $error("select write did not close the window");
  a_cde_rewrite: assert property (
    divider_change_enable && wr_div && (div_wdata == DIVCTL_CDE_ONLY) &&
      (cde_cnt != CDE_WINDOW - 3'h1) |=> divider_change_enable)
    else $error("rewriting change enable closed the window");
  a_wake_resume: assert property (
    WAKE_PULSE |-> (state == ST_RUN) && ($past(state) == ST_HOLD))
    else $error("wake pulse outside resume");

  c_div_change: cover property (wr_div && divider_change_enable);
  c_sleep_wake: cover property (WAKE_PULSE);
  c_pdown: cover property ((state == ST_SLEEP) && (slept_mode == SM_PDOWN));
  c_cde_timeout: cover property ($fell(divider_change_enable) && !$past(wr_div));
  c_cde_rewrite: cover property (divider_change_enable && wr_div && (div_wdata == DIVCTL_CDE_ONLY));

endmodule : clk_sleep_ctrl

// ---- inc/clk_sleep_pkg.sv ----
// constants, encodings and register map of the clock and sleep controller
// What this block does
// - reset loads factory value into oscillator trim
// - top trim bit selects low or high range
// - low seven trim bits tune within range
// - divider select changes only while enabled
// - enable sets only when other bits zero
// - enable clears after four cycles or write
// - rewriting enable neither restarts nor clears window
// - divider factor is two to select power
// - divided clock drives core and synchronous domains
// - fuse chooses divider reset value 0 or 3
// - select values 0 to 8 writable after reset
// - sleep needs enable bit plus sleep instruction
// - three-bit field picks one of six modes
// - clocks kept per mode, core always stopped
// - save, standby, extended standby clock sets
// - wake sources accepted per sleep mode
// - outside idle external pins wake by level
// - brown-out disable only in four deep modes
// - wake, hold four cycles after start-up
// - storage contents untouched across sleep
// - reset during sleep restarts from reset
// - encodings 000 idle to 011 save
// - 110 standby, 111 extended, six-cycle wake
// - divider change without glitch or short period
// - new division after old plus new period
package clk_sleep_pkg;
  localparam logic [7:0] OFS_TRIM     = 8'h00;
  localparam logic [7:0] OFS_DIVCTL   = 8'h04;
  localparam logic [7:0] OFS_SLEEPCTL = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam int         DIVCTL_CDE   = 7;
  localparam logic [7:0] DIVCTL_CDE_ONLY = 8'h80;
  localparam logic [3:0] DIVSEL_RST_FAST = 4'h0;
  localparam logic [3:0] DIVSEL_RST_DIV8 = 4'h3;
  localparam logic [3:0] DIVSEL_MAX      = 4'h8;
  localparam int         SLP_SE   = 0;
  localparam int         SLP_BODS = 4;
  localparam logic [2:0] CDE_WINDOW  = 3'h4;
  localparam logic [3:0] STARTUP_CK  = 4'h6;
  localparam logic [3:0] HOLD_CK     = 4'h4;
  localparam logic [2:0] SM_IDLE  = 3'h0;
  localparam logic [2:0] SM_ADCNR = 3'h1;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  localparam logic [2:0] SM_PSAVE = 3'h3;
  localparam logic [2:0] SM_STBY  = 3'h6;
  localparam logic [2:0] SM_XSTBY = 3'h7;
  // wake source bit positions
  localparam int WK_EXT_LVL  = 0;
  localparam int WK_EXT_EDGE = 1;
  localparam int WK_PINCHG   = 2;
  localparam int WK_TWI      = 3;
  localparam int WK_TIMER2   = 4;
  localparam int WK_MEMRDY   = 5;
  localparam int WK_ADC      = 6;
  localparam int WK_WDT      = 7;
  localparam int WK_OTHER    = 8;
  localparam logic [8:0] WMASK_IDLE  = 9'h1ff;
  localparam logic [8:0] WMASK_ADCNR = 9'h0fd;
  localparam logic [8:0] WMASK_PDOWN = 9'h08d;
  localparam logic [8:0] WMASK_PSAVE = 9'h09d;
  // domain bits {tosc,main,asy,adc,io,flash,cpu}
  localparam logic [6:0] DOM_RUN   = 7'h7f;
  localparam logic [6:0] DOM_IDLE  = 7'h7c;
  localparam logic [6:0] DOM_ADCNR = 7'h78;
  localparam logic [6:0] DOM_PDOWN = 7'h00;
  localparam logic [6:0] DOM_PSAVE = 7'h50;
  localparam logic [6:0] DOM_STBY  = 7'h20;
  localparam logic [6:0] DOM_XSTBY = 7'h70;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_START = 2'b10,
    ST_HOLD  = 2'b11
  } pwr_state_t;
endpackage : clk_sleep_pkg

// ---- sim/cpu_core_model.sv ----
// core model that issues the sleep instruction as a one-cycle pulse
`timescale 1ns/1ps
module cpu_core_model
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic core_en,
  input  wire logic exec_req,
  output logic      sleep_exec
);
  // the instruction only executes while the core clock runs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sleep_exec <= 1'b0;
    else
      sleep_exec <= exec_req & core_en;
  end
endmodule : cpu_core_model

// ---- sim/clock_divider_trim_sleep_ctrl_test.sv ----
// self-checking bench for the clock divider, trim and sleep controller
`timescale 1ns/1ps
module clock_divider_trim_sleep_ctrl_test;
  import clk_sleep_pkg::*;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, exec_req, sleep_exec;
  logic [7:0]  paddr, ftrim, trim, t;
  logic [31:0] pwdata, prdata;
  logic [8:0]  wake;
  logic        fuse, t2;
  logic        core_en, flash_en, io_en, adc_en, asy_en, main_en, tosc_en, bod_off, wake_pulse;
  int          seed, miscompares, checked, cyc, wk_start, n;
  logic [32:0] rd_q[$];
  int          wk_q[$];
  logic [2:0]  mode_tab[6] = '{SM_IDLE, SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY, SM_XSTBY};
  logic [6:0]  dom_tab[6] = '{DOM_IDLE, DOM_ADCNR, DOM_PDOWN, DOM_PSAVE, DOM_STBY, DOM_XSTBY};

  clk_sleep_ctrl u_dut (.CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .FACTORY_TRIM(ftrim), .DIVIDE_BY_EIGHT_FUSE(fuse),
    .SLEEP_EXEC(sleep_exec), .WAKE_SRC(wake), .T2_ASYNC(t2), .OSCILLATOR_TRIM(trim),
    .CORE_CLK_EN(core_en), .FLASH_CLK_EN(flash_en), .IO_CLK_EN(io_en), .ADC_CLK_EN(adc_en),
    .ASY_CLK_EN(asy_en), .MAIN_OSC_EN(main_en), .TIMER_OSC_EN(tosc_en), .BOD_OFF(bod_off),
    .WAKE_PULSE(wake_pulse));
  cpu_core_model u_core (.clk(clk), .rst_b(rst_b), .core_en(core_en), .exec_req(exec_req),
    .sleep_exec(sleep_exec));

  always #2 clk = ~clk;

  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chk_reg(input logic [32:0] got, input logic [32:0] exp);
    chk(got, exp);
  endtask : chk_reg

  task chk_wake(input int got, input int exp);
    chk(33'(got), 33'(exp));
  endtask : chk_wake

  task chk_clk(input logic [7:0] got, input logic [7:0] exp);
    chk({25'h0, got}, {25'h0, exp});
  endtask : chk_clk

  // request held until pready is seen high; caller starts just after an edge
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
  endtask : xfer

  task rd(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    rd_q.push_back({err, d});
    xfer(1'b0, a, d);
  endtask : rd

  task idle;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : idle

  task sleep_cmd;
    idle();
    exec_req <= 1'b1;
    @(posedge clk);
    exec_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : sleep_cmd

  // timeout and cycle count
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end

  // monitor: takes the oldest note when a result shows up
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0)
      chk_reg({pslverr, prdata}, rd_q.pop_front());
    if (wake_pulse === 1'b1 && wk_q.size() > 0)
      chk_wake(cyc - wk_start, wk_q.pop_front());
  end

  initial
  begin
    seed = 35599;
    ftrim = 8'($random(seed));
    {clk, rst_b, psel, penable, pwrite, exec_req, paddr, pwdata, wake} = '0;
    {miscompares, checked, cyc, wk_start} = '0;
    fuse = 1'b1;
    t2 = 1'b1;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_TRIM, {24'h0, ftrim});
    rd(OFS_DIVCTL, 32'h03);
    t = 8'($random(seed));
    xfer(1'b1, OFS_TRIM, {24'h0, t});
    rd(OFS_TRIM, {24'h0, t});
    chk_reg({25'h0, trim}, {25'h0, t});
    xfer(1'b1, OFS_DIVCTL, 32'h05);
    xfer(1'b1, OFS_DIVCTL, 32'h81);
    rd(OFS_DIVCTL, 32'h03);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    rd(OFS_DIVCTL, 32'h83);
    rd(OFS_DIVCTL, 32'h03);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    xfer(1'b1, OFS_DIVCTL, 32'h01);
    rd(OFS_DIVCTL, 32'h03);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    xfer(1'b1, OFS_DIVCTL, 32'h0b);
    rd(OFS_DIVCTL, 32'h03);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    xfer(1'b1, OFS_DIVCTL, 32'h08);
    rd(OFS_DIVCTL, 32'h08);
    idle();
    n = 0;
    repeat (512)
    begin
      @(posedge clk);
      n += int'(core_en);
    end
    chk_clk(8'(n), 8'h02);
    xfer(1'b1, OFS_DIVCTL, 32'h80);
    xfer(1'b1, OFS_DIVCTL, 32'h00);
    rd(OFS_DIVCTL, 32'h00);
    rd(8'h10, 32'h0, 1'b1);
    idle();
    // the new division only applies once the long period has wrapped
    repeat (256) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      t2 <= 1'($random(seed));
      xfer(1'b1, OFS_SLEEPCTL, {27'h0, 1'b1, mode_tab[i], 1'b1});
      sleep_cmd();
      rd(OFS_STATUS, 32'h1);
      chk_clk({1'b0, tosc_en, main_en, asy_en, adc_en, io_en, flash_en, core_en},
              {1'b0, dom_tab[i] & {t2, 1'b1, t2, 4'hf}});
      chk_clk({7'h0, bod_off}, {7'h0, mode_tab[i] >= SM_PDOWN});
      if (i > 0)
      begin
        wake <= 9'h102;
        rd(OFS_STATUS, 32'h1);
      end
      idle();
      wake <= 9'h080;
      wk_start = cyc;
      wk_q.push_back(int'(STARTUP_CK) + int'(HOLD_CK) + 2);
      repeat (20) @(posedge clk);
      wake <= 9'h000;
      @(posedge clk);
      rd(OFS_TRIM, {24'h0, t});
    end
    xfer(1'b1, OFS_SLEEPCTL, 32'h0);
    sleep_cmd();
    rd(OFS_STATUS, 32'h0);
    xfer(1'b1, OFS_SLEEPCTL, 32'h5);
    sleep_cmd();
    rst_b <= 1'b0;
    fuse <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(OFS_STATUS, 32'h0);
    rd(OFS_DIVCTL, 32'h00);
    rd(OFS_TRIM, {24'h0, ftrim});
    idle();
    repeat (4) @(posedge clk);
    results();
  end
endmodule : clock_divider_trim_sleep_ctrl_test
